/* logic/baud_gen_pkg.sv */
// Notes on behaviour
// - Mode 0 shifts at input clock over two.
// - Mode 2 is clock/64, or clock/32 when doubled.
// - Doubling affects Mode 2 and Timer 1 rate, not the generator.
// - Outside Mode 0, baud clock divided by sixteen gives bit rate.
// - Timer ticks from divider or prescaler output.
// - Underflow reloads timer and emits one pulse, unless one was emitted the cycle before.
// - Run bit starts and stops timer.
// - Normal divider mode stops timer, ignores run.
// - Reload register reads current timer count.
// - Write while running loads timer at once.
// - Write while stopped loads after run set.
// - Prescaler divides by two to prescale select; selects above 5 divide by 32.
// - Rate is clock/(16*prescale*(reload+1)).
// - Fractional mode scales rate by increment/256.
// - Rate never exceeds input clock over 32.
// - Accumulator adds increment, pulse on carry.
// - Increment 0..255 gives clock times n/256.
// - Fractional pulse jitter at most one period.
// - Normal mode is up-counter reloading from increment.
// - Normal overflow sets flag and requests interrupt.
// - Normal mode output is clock/(256-increment).
// - Source select picks generator or Timer 1.
package baud_gen_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_RATE_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DIV_CTRL = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_INCREMENT = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_ACCUM = 3'h5;

  // Field positions
  localparam int BIT_DOUBLE_RATE = 7;
  localparam int BIT_RUN = 0;
  localparam int BIT_PRE_LO = 1;
  localparam int BIT_PRE_HI = 3;
  localparam int BIT_DIV_EN = 0;
  localparam int BIT_DIV_MODE = 1;
  localparam int BIT_OVF = 2;
  localparam int BIT_SRC_SEL = 3;

  // Writable masks; other bits read as zero, except BIT_OVF outside MASK_DIV_CTRL
  localparam logic [DATA_W-1:0] MASK_POWER_CTRL = 8'h80;
  localparam logic [DATA_W-1:0] MASK_RATE_CTRL = 8'hdf;
  localparam logic [DATA_W-1:0] MASK_DIV_CTRL = 8'h0b;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  // Largest prescale select that is honoured; above it the divider stays at /32
  localparam logic [2:0] PRE_MAX = 3'h5;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [7:0] COUNT_TOP = 8'hff;

  // Serial channel modes
  localparam logic [1:0] CH_MODE0 = 2'h0;
  localparam logic [1:0] CH_MODE2 = 2'h2;

  // Software register access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

/* logic/baud_gen.sv */
`timescale 1ns/1ps
module baud_gen
  import baud_gen_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire reg_req_t req,
  output logic [DATA_W-1:0] rdata,
  input wire logic [1:0] channel_mode,
  input wire logic timer1_overflow,
  output logic baud_clk_pulse,
  output logic bit_tick,
  output logic div_irq
);

  // Register state
  logic [DATA_W-1:0] power_ctrl_q;
  logic [DATA_W-1:0] power_ctrl_d;
  logic [DATA_W-1:0] rate_ctrl_q;
  logic [DATA_W-1:0] rate_ctrl_d;
  logic [DATA_W-1:0] reload_value_q;
  logic [DATA_W-1:0] reload_value_d;
  logic [DATA_W-1:0] div_ctrl_q;
  logic [DATA_W-1:0] div_ctrl_d;
  logic [DATA_W-1:0] increment_q;
  logic [DATA_W-1:0] increment_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Generator state
  logic [4:0] pre_cnt_q;
  logic [4:0] pre_cnt_d;
  logic [7:0] accum_q;
  logic [7:0] accum_d;
  logic [7:0] timer_q;
  logic [7:0] timer_d;
  logic load_pending_q;
  logic load_pending_d;
  logic run_prev_q;
  logic run_prev_d;
  logic gen_pulse_q;
  logic gen_pulse_d;
  logic t1_half_q;
  logic t1_half_d;
  logic [1:0] fix_cnt_q;
  logic [1:0] fix_cnt_d;
  logic [3:0] over_cnt_q;
  logic [3:0] over_cnt_d;
  logic baud_clk_q;
  logic baud_clk_d;
  logic bit_tick_q;
  logic bit_tick_d;
  logic div_irq_q;
  logic div_irq_d;

  // Decoded control
  logic double_rate_sel;
  logic run_bit;
  logic [2:0] prescale_sel;
  logic divider_enable;
  logic divider_mode_sel;
  logic variable_source_sel;
  logic timer_run;
  logic [4:0] pre_mask;
  logic div_tick;
  logic divider_output_clock;
  logic timer_tick;
  logic [8:0] frac_sum;
  logic normal_ovf;
  logic reload_wr;
  logic run_rise;
  logic gen_raw;
  logic t1_pulse;
  logic var_pulse;

  assign double_rate_sel = power_ctrl_q[BIT_DOUBLE_RATE];
  assign run_bit = rate_ctrl_q[BIT_RUN];
  assign prescale_sel = rate_ctrl_q[BIT_PRE_HI:BIT_PRE_LO];
  assign divider_enable = div_ctrl_q[BIT_DIV_EN];
  assign divider_mode_sel = div_ctrl_q[BIT_DIV_MODE];
  assign variable_source_sel = div_ctrl_q[BIT_SRC_SEL];

  // Normal divider mode takes the timer away from baud generation
  assign timer_run = run_bit && !(divider_enable && divider_mode_sel);

  // Prescaler: reserved selects are clamped so the counter never overruns
  always_comb
  begin
    pre_mask = 5'h00;
    if (prescale_sel > PRE_MAX)
    begin
      pre_mask = 5'h1f;
    end
    else
    begin
      pre_mask = 5'((6'h01 << prescale_sel) - 6'h01);
    end
  end

  assign div_tick = ((pre_cnt_q & pre_mask) == pre_mask);

  // Fractional adder; carry out of bit 7 is the divider output pulse
  assign frac_sum = {1'b0, accum_q} + {1'b0, increment_q};
  assign divider_output_clock = divider_enable && !divider_mode_sel && div_tick
    && frac_sum[8];
  assign normal_ovf = divider_enable && divider_mode_sel && div_tick
    && (accum_q == COUNT_TOP);

  // Timer clock source
  assign timer_tick = divider_enable ? divider_output_clock : div_tick;

  assign reload_wr = req.wr && (req.addr == OFS_RELOAD);
  assign run_rise = run_bit && !run_prev_q;

  // Raw underflow pulse, before the rate cap
  assign gen_raw = timer_run && timer_tick && (timer_q == 8'h00) && !reload_wr;

  // Timer 1 overflow halves unless doubled; the generator never sees doubling
  assign t1_pulse = timer1_overflow && (double_rate_sel || t1_half_q);
  assign var_pulse = variable_source_sel ? gen_pulse_q : t1_pulse;

  // Register file and bus read
  always_comb
  begin
    power_ctrl_d = power_ctrl_q;
    rate_ctrl_d = rate_ctrl_q;
    reload_value_d = reload_value_q;
    div_ctrl_d = div_ctrl_q;
    increment_d = increment_q;
    rdata_d = rdata_q;
    if (req.wr)
    begin
      case (req.addr)
        OFS_POWER_CTRL: power_ctrl_d = req.wdata & MASK_POWER_CTRL;
        OFS_RATE_CTRL: rate_ctrl_d = req.wdata & MASK_RATE_CTRL;
        OFS_RELOAD: reload_value_d = req.wdata;
        OFS_DIV_CTRL:
        begin
          div_ctrl_d = req.wdata & MASK_DIV_CTRL;
          // Flag is software-clearable only; writing one keeps its old value
          div_ctrl_d[BIT_OVF] = div_ctrl_q[BIT_OVF] & req.wdata[BIT_OVF];
        end
        OFS_INCREMENT: increment_d = req.wdata;
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write in the same cycle
    if (normal_ovf)
    begin
      div_ctrl_d[BIT_OVF] = 1'b1;
    end
    if (req.rd)
    begin
      case (req.addr)
        OFS_POWER_CTRL: rdata_d = power_ctrl_q;
        OFS_RATE_CTRL: rdata_d = rate_ctrl_q;
        OFS_RELOAD: rdata_d = timer_q;
        OFS_DIV_CTRL: rdata_d = div_ctrl_q;
        OFS_INCREMENT: rdata_d = increment_q;
        OFS_ACCUM: rdata_d = accum_q;
        default: rdata_d = RST_BYTE;
      endcase
    end
    else
    begin
      rdata_d = RST_BYTE;
    end
  end

  // Prescaler, divider and reload timer
  always_comb
  begin
    pre_cnt_d = 5'(pre_cnt_q + 5'h01);
    accum_d = accum_q;
    timer_d = timer_q;
    load_pending_d = load_pending_q;
    run_prev_d = run_bit;
    gen_pulse_d = 1'b0;
    div_irq_d = 1'b0;
    if (div_tick)
    begin
      pre_cnt_d = 5'h00;
    end
    // Divider: disabled holds the accumulator
    if (divider_enable && div_tick)
    begin
      if (divider_mode_sel)
      begin
        if (normal_ovf)
        begin
          accum_d = increment_q;
          div_irq_d = 1'b1;
        end
        else
        begin
          accum_d = 8'(accum_q + 8'h01);
        end
      end
      else
      begin
        accum_d = frac_sum[7:0];
      end
    end
    // Reload timer: a write while running goes straight in
    if (reload_wr)
    begin
      if (run_bit)
      begin
        timer_d = req.wdata;
        load_pending_d = 1'b0;
      end
      else
      begin
        load_pending_d = 1'b1;
      end
    end
    else if (run_rise && load_pending_q)
    begin
      timer_d = reload_value_q;
      load_pending_d = 1'b0;
    end
    else if (timer_run && timer_tick)
    begin
      if (timer_q == 8'h00)
      begin
        timer_d = reload_value_q;
      end
      else
      begin
        timer_d = 8'(timer_q - 8'h01);
      end
    end
    // Cap: never two pulses back to back, so the rate stays at or below clock/32
    gen_pulse_d = gen_raw && !gen_pulse_q;
  end

  // Channel clock selection and oversampling
  always_comb
  begin
    fix_cnt_d = 2'(fix_cnt_q + 2'h1);
    t1_half_d = t1_half_q;
    over_cnt_d = over_cnt_q;
    baud_clk_d = 1'b0;
    bit_tick_d = 1'b0;
    if (timer1_overflow)
    begin
      t1_half_d = !t1_half_q;
    end
    case (channel_mode)
      CH_MODE0:
      begin
        // Shift clock is the bit rate itself; no oversampling
        baud_clk_d = fix_cnt_q[0];
        bit_tick_d = fix_cnt_q[0];
        over_cnt_d = 4'h0;
      end
      CH_MODE2:
      begin
        baud_clk_d = double_rate_sel ? fix_cnt_q[0] : (fix_cnt_q == 2'h3);
      end
      default:
      begin
        baud_clk_d = var_pulse;
      end
    endcase
    // Sixteen baud clocks make one bit time
    if (channel_mode != CH_MODE0 && baud_clk_d)
    begin
      over_cnt_d = 4'(over_cnt_q + 4'h1);
      bit_tick_d = (over_cnt_q == OVERSAMPLE_LAST);
    end
  end

  // All state registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      power_ctrl_q <= RST_BYTE;
      rate_ctrl_q <= RST_BYTE;
      reload_value_q <= RST_BYTE;
      div_ctrl_q <= RST_BYTE;
      increment_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
      pre_cnt_q <= 5'h00;
      accum_q <= 8'h00;
      timer_q <= 8'h00;
      load_pending_q <= 1'b0;
      run_prev_q <= 1'b0;
      gen_pulse_q <= 1'b0;
      t1_half_q <= 1'b0;
      fix_cnt_q <= 2'h0;
      over_cnt_q <= 4'h0;
      baud_clk_q <= 1'b0;
      bit_tick_q <= 1'b0;
      div_irq_q <= 1'b0;
    end
    else
    begin
      power_ctrl_q <= power_ctrl_d;
      rate_ctrl_q <= rate_ctrl_d;
      reload_value_q <= reload_value_d;
      div_ctrl_q <= div_ctrl_d;
      increment_q <= increment_d;
      rdata_q <= rdata_d;
      pre_cnt_q <= pre_cnt_d;
      accum_q <= accum_d;
      timer_q <= timer_d;
      load_pending_q <= load_pending_d;
      run_prev_q <= run_prev_d;
      gen_pulse_q <= gen_pulse_d;
      t1_half_q <= t1_half_d;
      fix_cnt_q <= fix_cnt_d;
      over_cnt_q <= over_cnt_d;
      baud_clk_q <= baud_clk_d;
      bit_tick_q <= bit_tick_d;
      div_irq_q <= div_irq_d;
    end
  end

  assign rdata = rdata_q;
  assign baud_clk_pulse = baud_clk_q;
  assign bit_tick = bit_tick_q;
  assign div_irq = div_irq_q;

endmodule

/* verification/baud_gen_monitor.sv */
`timescale 1ns/1ps
module baud_gen_monitor
  import baud_gen_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire reg_req_t req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] channel_mode,
  input wire logic timer1_overflow,
  input wire logic baud_clk_pulse,
  input wire logic bit_tick,
  input wire logic div_irq
);
  logic run_q, nm_q, src_q;
  logic [2:0] stop_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadow of the control bits; the counter lets pipelined pulses drain first
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      run_q <= 1'b0;
      nm_q <= 1'b0;
      src_q <= 1'b0;
      stop_q <= 3'h0;
    end
    else
    begin
      if (req.wr && req.addr == OFS_RATE_CTRL)
        run_q <= req.wdata[BIT_RUN];
      if (req.wr && req.addr == OFS_DIV_CTRL)
      begin
        nm_q <= req.wdata[BIT_DIV_EN] & req.wdata[BIT_DIV_MODE];
        src_q <= req.wdata[BIT_SRC_SEL];
      end
      if ((!run_q || nm_q) && src_q && channel_mode[0])
        stop_q <= (stop_q == 3'h7) ? stop_q : stop_q + 3'h1;
      else
        stop_q <= 3'h0;
    end
  end
  chk_rd_idle: assert property (!req.rd |=> rdata == '0)
    else $error("read data not idle");
  chk_rd_unmap: assert property (req.rd && req.addr > OFS_ACCUM |=> rdata == '0)
    else $error("unmapped read not zero");
  chk_pwr_rsvd: assert property (req.rd && req.addr == OFS_POWER_CTRL |=>
    (rdata & ~MASK_POWER_CTRL) == '0) else $error("reserved bits set");
  chk_fixed_cap: assert property (baud_clk_pulse |=> !baud_clk_pulse)
    else $error("baud pulses adjacent");
  chk_mode0_tie: assert property ((channel_mode == CH_MODE0)[*4] |->
    baud_clk_pulse == bit_tick) else $error("mode 0 shift clock split");
  chk_mode0_rate: assert property ((channel_mode == CH_MODE0)[*4] ##0 baud_clk_pulse |->
    ##2 (baud_clk_pulse || channel_mode != CH_MODE0)) else $error("mode 0 rate wrong");
  chk_gen_stop: assert property (stop_q == 3'h7 |-> !baud_clk_pulse)
    else $error("stopped generator pulsed");
  chk_irq_mode: assert property ((!nm_q)[*4] |-> !div_irq)
    else $error("irq outside normal mode");
  cover property (div_irq);
  cover property (bit_tick && channel_mode[0]);
  cover property (req.rd && req.addr == OFS_RELOAD);
endmodule

/* verification/serial_channel_model.sv */
`timescale 1ns/1ps
module serial_channel_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic baud_clk_pulse,
  input wire logic bit_tick,
  input wire logic clr,
  output logic [15:0] baud_cnt_q,
  output logic [7:0] per_bit_q
);
  logic [7:0] run_q;
  // Counts baud clocks, and baud clocks per bit time
  always_ff @(posedge clk)
  begin
    if (!resetn || clr)
    begin
      baud_cnt_q <= 16'h0000;
      run_q <= 8'h00;
      per_bit_q <= 8'h00;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 16'(baud_clk_pulse);
      run_q <= bit_tick ? 8'h00 : run_q + 8'(baud_clk_pulse);
      if (bit_tick)
        per_bit_q <= run_q + 8'(baud_clk_pulse);
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import baud_gen_pkg::*;
  logic clk, resetn, t1, t1_en, baud, bit_t, irq, clr;
  reg_req_t req;
  logic [DATA_W-1:0] rdata, got;
  logic [1:0] mode;
  logic [15:0] baud_cnt;
  logic [7:0] per_bit;
  int n_errors = 0;
  int compares = 0;
  baud_gen i_dut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .channel_mode(mode),
    .timer1_overflow(t1), .baud_clk_pulse(baud), .bit_tick(bit_t), .div_irq(irq));
  serial_channel_model i_chan (.clk(clk), .resetn(resetn), .baud_clk_pulse(baud),
    .bit_tick(bit_t), .clr(clr), .baud_cnt_q(baud_cnt), .per_bit_q(per_bit));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Timer 1 overflows every other cycle
  always @(posedge clk) t1 <= t1_en & ~t1;
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 got = rdata;
  endtask
  task setm(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? baud : (s == 1) ? bit_t : irq;
  endfunction
  // Skips settling pulses, then measures the cycles between two pulses
  task gap(input int s, input int e);
    int n;
    @(negedge clk);
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (!sig(s) && n < 3000);
    end
    chk(8'(n), 8'(e));
  endtask
  task quiet;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (40) @(posedge clk);
    chk(baud_cnt[7:0], 8'h00);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial
  begin
    req = '0;
    mode = CH_MODE0;
    resetn = 1'b0;
    t1_en = 1'b0;
    clr = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 7; a++)
    begin
      rd(3'(a));
      chk(got, 8'h00);
    end
    wr(OFS_POWER_CTRL, 8'hff);
    rd(OFS_POWER_CTRL);
    chk(got, 8'h80);
    gap(0, 2);
    setm(CH_MODE2);
    gap(0, 2);
    gap(1, 32);
    wr(OFS_POWER_CTRL, 8'h00);
    gap(0, 4);
    gap(1, 64);
    setm(2'h1);
    wr(OFS_DIV_CTRL, 8'h08);
    wr(OFS_RELOAD, 8'h03);
    wr(OFS_RATE_CTRL, 8'h03);
    gap(0, 8);
    gap(1, 128);
    chk(per_bit, 8'h10);
    wr(OFS_POWER_CTRL, 8'h80);
    gap(0, 8);
    wr(OFS_RELOAD, 8'h07);
    gap(0, 16);
    rd(OFS_RELOAD);
    chk(got & 8'hf8, 8'h00);
    wr(OFS_RATE_CTRL, 8'h02);
    quiet();
    wr(OFS_RELOAD, 8'h40);
    rd(OFS_RELOAD);
    chk(got & 8'hf8, 8'h00);
    wr(OFS_RELOAD, 8'h02);
    wr(OFS_RATE_CTRL, 8'h01);
    gap(0, 3);
    wr(OFS_RATE_CTRL, 8'h00);
    wr(OFS_RELOAD, 8'h00);
    wr(OFS_RATE_CTRL, 8'h01);
    gap(0, 2);
    wr(OFS_INCREMENT, 8'h80);
    wr(OFS_DIV_CTRL, 8'h09);
    wr(OFS_RELOAD, 8'h01);
    gap(0, 4);
    wr(OFS_INCREMENT, 8'h40);
    gap(0, 8);
    rd(OFS_ACCUM);
    chk(got & 8'h3f, 8'h00);
    wr(OFS_INCREMENT, 8'h00);
    quiet();
    wr(OFS_INCREMENT, 8'hfd);
    wr(OFS_DIV_CTRL, 8'h0b);
    gap(2, 3);
    rd(OFS_ACCUM);
    chk(got & 8'hfc, 8'hfc);
    quiet();
    rd(OFS_DIV_CTRL);
    chk(got, 8'h0f);
    // Leave normal mode first, so no overflow can race the clearing write
    wr(OFS_DIV_CTRL, 8'h0c);
    rd(OFS_DIV_CTRL);
    chk(got, 8'h0c);
    wr(OFS_DIV_CTRL, 8'h08);
    rd(OFS_DIV_CTRL);
    chk(got, 8'h08);
    wr(OFS_DIV_CTRL, 8'h00);
    setm(2'h3);
    t1_en <= 1'b1;
    gap(0, 2);
    wr(OFS_POWER_CTRL, 8'h00);
    gap(0, 4);
    wr(3'h6, 8'hff);
    rd(3'h6);
    chk(got, 8'h00);
    end_sim();
  end
endmodule
bind baud_gen baud_gen_monitor i_mon (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
  .channel_mode(channel_mode), .timer1_overflow(timer1_overflow),
  .baud_clk_pulse(baud_clk_pulse), .bit_tick(bit_tick), .div_irq(div_irq));
